// ### rtl/brt_pkg.sv
package brt_pkg;
  // ******************************
  // widths and encodings
  // ******************************
  localparam int VW = 12;            // volts, 1 V per lsb
  localparam logic [2:0] MODE_COAST = 3'h0;
  localparam logic [2:0] MODE_DECEL = 3'h1;
  localparam logic [2:0] MODE_CONTINUE = 3'h2;
  localparam logic [2:0] MODE_COAST_IN = 3'h3;
  localparam logic [2:0] MODE_DECEL_IN = 3'h4;
  localparam logic [2:0] MODE_RESET = MODE_COAST;
  // ******************************
  // bus levels, 400/480 V class
  // ******************************
  localparam logic [VW-1:0] CLOSE_DROP_V = 12'h078;   // 120 V
  localparam logic [VW-1:0] TRIG1_DROP_V = 12'h078;   // 120 V
  localparam logic [VW-1:0] OPEN_DROP_V = 12'h0B4;    // 180 V
  localparam logic [VW-1:0] TRIG2_DROP_V = 12'h0B4;   // 180 V
  localparam logic [VW-1:0] RECOVER_DROP_V = 12'h03C; // 60 V
  localparam logic [VW-1:0] VMIN_V = 12'h131;         // 305 V
  localparam logic [VW-1:0] HALF_VMIN_V = 12'h131;    // 305 V, open equals floor
  localparam int COAST_PCT = 73;
  localparam int DECEL_PCT = 82;
  // ******************************
  // timing
  // ******************************
  localparam int CLK_HZ = 20_000_000;
  localparam int RECOVER_MS = 20;
  localparam int RECOVER_CYC = (CLK_HZ / 1000) * RECOVER_MS;
  localparam int SLEW_MV_PER_MIN = 2400; // 2.4 V per minute
  // cycles per 1 V step; split so that no product leaves the int range
  localparam int SLEW_CYC = (CLK_HZ / 100) * (60_000 / (SLEW_MV_PER_MIN / 100));
  localparam int TMR_W = 32;
  // ******************************
  // supervisor states
  // ******************************
  typedef enum logic [5:0] {
    BRT_IDLE = 6'h01,
    BRT_RUN = 6'h02,
    BRT_COAST = 6'h04,
    BRT_INERTIA = 6'h08,
    BRT_RECON = 6'h10,
    BRT_ACCEL = 6'h20
  } brt_state_t;
endpackage : brt_pkg

// ### rtl/brt_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the bus average between the filter and the supervisor
interface brt_avg_if;
  import brt_pkg::*;
  logic [VW-1:0] avg;
  logic load;
  logic hold;
  logic no_rise;
  modport flt (output avg, input load, input hold, input no_rise);
  modport sup (input avg, output load, output hold, output no_rise);
endinterface : brt_avg_if
`default_nettype wire

// ### rtl/brt_avg.sv
`timescale 1ns/1ps
`default_nettype none
module brt_avg
  import brt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [VW-1:0] vbus_i,
  brt_avg_if.flt a
);
  // ******************************
  // slow ramp of the bus average
  // ******************************
  localparam logic [TMR_W-1:0] SLEW_LAST = TMR_W'(SLEW_CYC - 1);
  logic [VW-1:0] avg_r, avg_nxt;
  logic [TMR_W-1:0] div_r, div_nxt;
  // one volt step per slew period keeps the average near nominal
  always_comb begin
    avg_nxt = avg_r;
    div_nxt = (div_r == SLEW_LAST) ? '0 : div_r + 1'b1;
    if (a.load) begin
      avg_nxt = vbus_i;
      div_nxt = '0;
    end else if (a.hold) begin
      div_nxt = '0;
    end else if (div_r == SLEW_LAST) begin
      if (vbus_i > avg_r && !a.no_rise) avg_nxt = avg_r + 1'b1;
      else if (vbus_i < avg_r) avg_nxt = avg_r - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avg_r <= '0;
      div_r <= '0;
    end else begin
      avg_r <= avg_nxt;
      div_r <= div_nxt;
    end
  end
  assign a.avg = avg_r;
endmodule : brt_avg
`default_nettype wire

// ### rtl/brt_top.sv
`timescale 1ns/1ps
`default_nettype none
module brt_top
  import brt_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [VW-1:0] vbus_i,        // newest sample, same clock
  input wire logic [2:0] mode_i,
  input wire logic trig_sel_i,             // 0 standard first, 1 second level
  input wire logic trig_adj_en_i,
  input wire logic [VW-1:0] trig_adj_i,    // adjusted drop below average
  input wire logic loss_lvl_fn_i,
  input wire logic loss_lvl_pin_i,         // pin
  input wire logic [VW-1:0] loss_lvl_i,
  input wire logic [TMR_W-1:0] loss_time_i,
  input wire logic alarm_mask_loss_i,
  input wire logic fault_mask_loss_i,
  input wire logic fault_mask_uv_i,
  input wire logic fault_reset_i,
  input wire logic two_wire_i,
  input wire logic [1:0] enable_pin_i,     // pins, all must be high
  input wire logic [1:0] not_stop_pin_i,
  input wire logic [1:0] run_pin_i,
  input wire logic running_i,
  input wire logic freq_zero_i,
  input wire logic decel_i,
  input wire logic recon_done_i,
  output logic inv_en_o,
  output logic relay_o,
  output logic decel_reg_o,
  output logic [VW-1:0] vinertia_o,
  output logic reconnect_o,
  output logic accel_o,
  output logic prog_stop_o,
  output logic alarm_loss_o,
  output logic status_alarm_o,
  output logic loss_timeout_fault_o,
  output logic undervoltage_fault_o,
  output logic run_permit_o,
  output logic [TMR_W-1:0] loss_timer_o,
  output logic [VW-1:0] bus_average_readout_o
);
  // ******************************
  // input synchronisers
  // ******************************
  logic [6:0] s1_r, s2_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {loss_lvl_pin_i, enable_pin_i, not_stop_pin_i, run_pin_i};
      s2_r <= s1_r;
    end
  end
  logic lvl_s, en_all, ns_all, run_all;
  assign lvl_s = s2_r[6];
  assign en_all = &s2_r[5:4];
  assign ns_all = &s2_r[3:2];
  assign run_all = &s2_r[1:0];
  // supervisor registers, declared early because thresholds and permit read them
  logic relay_r, relay_nxt, alarm_r, alarm_nxt, lt_fault_r, lt_fault_nxt;
  logic uv_fault_r, uv_fault_nxt;

  // ******************************
  // thresholds
  // ******************************
  brt_avg_if a();
  logic [VW-1:0] avg;
  assign avg = a.avg;
  // saturating drop below the average, reused for every level but the vmin floor
  function automatic logic [VW-1:0] below(input logic [VW-1:0] v, input logic [VW-1:0] d);
    below = (v > d) ? v - d : '0;
  endfunction : below
  function automatic logic [VW-1:0] floor_at(input logic [VW-1:0] v, input logic [VW-1:0] f);
    floor_at = (v < f) ? f : v;
  endfunction : floor_at
  localparam logic [VW+6:0] PCT_COAST = (VW+7)'(COAST_PCT);
  localparam logic [VW+6:0] PCT_DECEL = (VW+7)'(DECEL_PCT);
  localparam logic [VW+6:0] HUNDRED = (VW+7)'(100);
  logic is_half, is_decel;
  assign is_half = (mode_i == MODE_CONTINUE);
  assign is_decel = (mode_i == MODE_DECEL) || (mode_i == MODE_DECEL_IN);
  logic [VW-1:0] vmin, vclose, vopen, vrecov, vtrig_std, vtrig;
  assign vmin = is_half ? HALF_VMIN_V : VMIN_V;
  assign vclose = below(avg, CLOSE_DROP_V);
  assign vopen = is_half ? vmin : floor_at(below(avg, OPEN_DROP_V), vmin);
  assign vrecov = below(avg, RECOVER_DROP_V);
  assign vtrig_std = trig_sel_i ? below(avg, TRIG2_DROP_V) : below(avg, TRIG1_DROP_V);
  always_comb begin
    vtrig = vtrig_std;
    if (trig_adj_en_i) vtrig = below(avg, trig_adj_i);
    if (loss_lvl_fn_i && lvl_s) vtrig = floor_at(below(avg, loss_lvl_i), vmin);
  end
  // percentage test on the newest sample, no rounding in the products
  logic pct_loss;
  assign pct_loss = is_decel ? ((VW+7)'(vbus_i) * HUNDRED <= (VW+7)'(avg) * PCT_DECEL)
                             : ((VW+7)'(vbus_i) * HUNDRED <= (VW+7)'(avg) * PCT_COAST);
  logic loss_det;
  assign loss_det = relay_r && (pct_loss || vbus_i < vtrig);

  // ******************************
  // run permit
  // ******************************
  logic fault_any;
  assign fault_any = lt_fault_r || uv_fault_r;
  assign run_permit_o = !fault_any && en_all && ns_all && (!two_wire_i || run_all);

  // ******************************
  // supervisor state machine
  // ******************************
  brt_state_t st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt, rec_r, rec_nxt;
  logic [VW-1:0] vin_r, vin_nxt;
  logic recovered;
  assign recovered = alarm_r && (rec_r >= TMR_W'(RECOVER_CYCLES - 1)) && vbus_i > vrecov;
  // the relay acts on bus level alone so the charge path is ready when power returns
  always_comb begin
    relay_nxt = relay_r;
    if (vbus_i < vopen) relay_nxt = 1'b0;
    else if (vbus_i > vclose || (!relay_r && avg == '0)) relay_nxt = 1'b1;
  end
  always_comb begin
    st_nxt = st_r;
    alarm_nxt = alarm_r;
    tmr_nxt = tmr_r;
    rec_nxt = rec_r;
    vin_nxt = vin_r;
    lt_fault_nxt = lt_fault_r && !fault_reset_i;
    uv_fault_nxt = uv_fault_r && !fault_reset_i;
    // recovery qualification restarts on any low sample
    if (!alarm_r || vbus_i <= vrecov) rec_nxt = '0;
    else if (rec_r != '1) rec_nxt = rec_r + 1'b1;
    if (alarm_r && tmr_r != '1) tmr_nxt = tmr_r + 1'b1;
    if (!alarm_r && loss_det) begin
      alarm_nxt = 1'b1;
      tmr_nxt = '0;
    end
    if (recovered) alarm_nxt = 1'b0;
    // fault sets win over a simultaneous reset
    if (alarm_r && tmr_r > loss_time_i && fault_mask_loss_i) lt_fault_nxt = 1'b1;
    if (vbus_i < vmin && fault_mask_uv_i && relay_r) uv_fault_nxt = 1'b1;
    unique case (st_r)
      BRT_IDLE: if (running_i && run_permit_o) st_nxt = BRT_RUN;
      BRT_RUN: begin
        if (!running_i) st_nxt = BRT_IDLE;
        else if (loss_det && is_decel) begin
          st_nxt = BRT_INERTIA;
          vin_nxt = avg;
        end else if (loss_det && !is_half) st_nxt = BRT_COAST;
        else if (is_half && (vbus_i < vopen || !en_all)) st_nxt = BRT_COAST;
      end
      BRT_INERTIA: begin
        if (freq_zero_i || vbus_i < vopen || !run_permit_o) st_nxt = BRT_COAST;
        else if (recovered) st_nxt = BRT_ACCEL;
      end
      BRT_COAST: if (!alarm_r && run_permit_o && running_i) st_nxt = BRT_RECON;
      BRT_RECON: begin
        if (!run_permit_o || (loss_det && !is_half)) st_nxt = BRT_COAST;
        else if (recon_done_i) st_nxt = BRT_ACCEL;
      end
      BRT_ACCEL: if (!run_permit_o || (loss_det && !is_half)) st_nxt = BRT_COAST;
        else st_nxt = BRT_RUN;
      default: st_nxt = BRT_IDLE;
    endcase
    if (fault_any && st_r != BRT_IDLE) st_nxt = BRT_COAST;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= BRT_IDLE;
      relay_r <= 1'b0;
      alarm_r <= 1'b0;
      tmr_r <= '0;
      rec_r <= '0;
      vin_r <= '0;
      lt_fault_r <= 1'b0;
      uv_fault_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      relay_r <= relay_nxt;
      alarm_r <= alarm_nxt;
      tmr_r <= tmr_nxt;
      rec_r <= rec_nxt;
      vin_r <= vin_nxt;
      lt_fault_r <= lt_fault_nxt;
      uv_fault_r <= uv_fault_nxt;
    end
  end

  // ******************************
  // average filter hookup
  // ******************************
  assign a.load = relay_nxt && !relay_r;
  assign a.hold = (st_r == BRT_INERTIA);
  assign a.no_rise = decel_i;
  brt_avg u_avg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .vbus_i(vbus_i),
    .a(a)
  );

  // ******************************
  // outputs
  // ******************************
  // output enable is dropped whenever the motor must coast
  assign inv_en_o = (st_r == BRT_RUN) || (st_r == BRT_INERTIA) || (st_r == BRT_RECON)
                    || (st_r == BRT_ACCEL);
  assign relay_o = relay_r;
  assign decel_reg_o = (st_r == BRT_INERTIA);
  assign vinertia_o = vin_r;
  assign reconnect_o = (st_r == BRT_RECON);
  assign accel_o = (st_r == BRT_ACCEL);
  assign prog_stop_o = is_half && (st_r == BRT_RUN) && (!ns_all || (two_wire_i && !run_all));
  assign alarm_loss_o = alarm_r;
  assign status_alarm_o = alarm_r && alarm_mask_loss_i;
  assign loss_timeout_fault_o = lt_fault_r;
  assign undervoltage_fault_o = uv_fault_r;
  assign loss_timer_o = tmr_r;
  assign bus_average_readout_o = avg;
endmodule : brt_top
`default_nettype wire

// ### tb/brt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module brt_monitor
  import brt_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [VW-1:0] vbus_i,
  input wire logic [2:0] mode_i,
  input wire logic alarm_mask_loss_i,
  input wire logic fault_mask_loss_i,
  input wire logic fault_mask_uv_i,
  input wire logic [TMR_W-1:0] loss_time_i,
  input wire logic [1:0] enable_pin_i,
  input wire logic recon_done_i,
  input wire logic inv_en_o,
  input wire logic relay_o,
  input wire logic decel_reg_o,
  input wire logic reconnect_o,
  input wire logic accel_o,
  input wire logic alarm_loss_o,
  input wire logic status_alarm_o,
  input wire logic loss_timeout_fault_o,
  input wire logic undervoltage_fault_o,
  input wire logic run_permit_o,
  input wire logic [TMR_W-1:0] loss_timer_o,
  input wire logic [VW-1:0] bus_average_readout_o
);
  logic [31:0] rec_r;
  logic [31:0] rec_nxt;
  logic coast_low;
  // ******************************
  // helper logic
  // ******************************
  // consecutive samples above the recovery level
  always_comb begin
    rec_nxt = (vbus_i + RECOVER_DROP_V > bus_average_readout_o) ? rec_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_i) begin
    rec_r <= rst_i ? 32'h0 : rec_nxt;
  end
  // loss while driving, coast reaction
  assign coast_low = (mode_i == MODE_COAST) && inv_en_o && relay_o &&
                     (100 * vbus_i <= 73 * bus_average_readout_o);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_recon;
    reconnect_o ##1 recon_done_i;
  endsequence
  // ******************************
  // assertions
  // ******************************
  a_coast_alarm: assert property (coast_low |=> alarm_loss_o)
    else $error("loss not flagged");
  a_coast_inv_off: assert property (coast_low |=> !inv_en_o)
    else $error("inverter still on after loss");
  a_status_masked: assert property (!alarm_mask_loss_i [*2] |-> !status_alarm_o)
    else $error("status alarm while masked");
  a_timeout_fault: assert property (alarm_loss_o && loss_timer_o > loss_time_i && fault_mask_loss_i
    |-> ##[1:2] loss_timeout_fault_o)
    else $error("timeout fault missing");
  a_uv_fault: assert property (relay_o && fault_mask_uv_i && vbus_i < VMIN_V
    |=> undervoltage_fault_o)
    else $error("undervoltage fault missing");
  a_relay_open: assert property (relay_o && mode_i != MODE_CONTINUE &&
    (vbus_i + OPEN_DROP_V < bus_average_readout_o)
    |=> !relay_o)
    else $error("relay stayed closed");
  a_alarm_holds: assert property (alarm_loss_o && rec_r < RECOVER_CYCLES - 2
    |=> alarm_loss_o)
    else $error("alarm cleared early");
  a_permit_fault: assert property (loss_timeout_fault_o || undervoltage_fault_o
    |-> !run_permit_o)
    else $error("permit despite fault");
  a_permit_pins: assert property ((enable_pin_i != 2'h3) [*3] |-> !run_permit_o)
    else $error("permit with enable low");
  a_avg_frozen: assert property (decel_reg_o [*3] |-> $stable(bus_average_readout_o))
    else $error("average moved in ride-through");
  a_recon_accel: assert property (s_recon |-> ##[0:3] accel_o)
    else $error("no acceleration after reconnect");
endmodule : brt_monitor
bind brt_top brt_monitor #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_mon (.*);
`default_nettype wire

// ### tb/brt_stage.sv
`timescale 1ns/1ps
`default_nettype none
// power stage: run state follows command, reconnect takes four cycles
module brt_stage (
  input wire logic clk_i,
  input wire logic run_cmd_i,
  input wire logic zero_req_i,
  input wire logic reconnect_i,
  input wire logic decel_reg_i,
  output logic running_o,
  output logic freq_zero_o,
  output logic decel_o,
  output logic recon_done_o
);
  int cnt = 0;
  // speed search is slow on purpose so the design must wait
  always @(posedge clk_i) begin
    running_o <= run_cmd_i;
    freq_zero_o <= zero_req_i;
    decel_o <= decel_reg_i;
    cnt <= reconnect_i ? cnt + 1 : 0;
    recon_done_o <= reconnect_i && cnt == 3;
  end
endmodule : brt_stage
`default_nettype wire

// ### tb/test_bus_power_loss_ride_through.sv
`timescale 1ns/1ps
`default_nettype none
module test_bus_power_loss_ride_through;
  import brt_pkg::*;
  logic clk_i, rst_i, trig_sel_i, trig_adj_en_i, loss_lvl_fn_i, loss_lvl_pin_i;
  logic alarm_mask_loss_i, fault_mask_loss_i, fault_mask_uv_i, fault_reset_i, two_wire_i;
  logic running_i, freq_zero_i, decel_i, recon_done_i, run_cmd, zero_req, r, a;
  logic [VW-1:0] vbus_i, trig_adj_i, loss_lvl_i, vinertia_o, bus_average_readout_o;
  logic [2:0] mode_i;
  logic [TMR_W-1:0] loss_time_i, loss_timer_o;
  logic [1:0] enable_pin_i, not_stop_pin_i, run_pin_i;
  logic inv_en_o, relay_o, decel_reg_o, reconnect_o, accel_o, prog_stop_o, alarm_loss_o;
  logic status_alarm_o, loss_timeout_fault_o, undervoltage_fault_o, run_permit_o;
  int miscompares = 0;
  int cmp_count = 0;
  brt_top #(.RECOVER_CYCLES(20)) i_brt_top (.*);
  brt_stage i_brt_stage (.clk_i(clk_i), .run_cmd_i(run_cmd), .zero_req_i(zero_req),
    .reconnect_i(reconnect_o), .decel_reg_i(decel_reg_o), .running_o(running_i),
    .freq_zero_o(freq_zero_i), .decel_o(decel_i), .recon_done_o(recon_done_i));
  // ******************************
  // helpers
  // ******************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #2;
    end
  endtask : tick
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", n, exp, got);
    end
  endtask : chk
  // restore the bus and note what the supervisor does on the way back
  task recov;
    r = 1'b0;
    a = 1'b0;
    vbus_i = 12'h28A;
    repeat (40) begin
      tick(1);
      r |= reconnect_o;
      a |= accel_o;
    end
  endtask : recov
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // ******************************
  // tests
  // ******************************
  initial begin
    {trig_sel_i, trig_adj_en_i, loss_lvl_fn_i, loss_lvl_pin_i, fault_reset_i} = 5'h00;
    {fault_mask_loss_i, fault_mask_uv_i, two_wire_i, run_cmd, zero_req} = 5'h00;
    {trig_adj_i, loss_lvl_i, mode_i, vbus_i} = '0;
    alarm_mask_loss_i = 1'b1;
    loss_time_i = 32'h0000_FFFF;
    {enable_pin_i, not_stop_pin_i, run_pin_i} = 6'h3F;
    rst_i = 1'b1;
    tick(16);
    chk("outs_rst", {inv_en_o, relay_o, alarm_loss_o, loss_timeout_fault_o}, 0);
    rst_i = 1'b0;
    vbus_i = 12'h28A; // 650 V
    tick(4);
    chk("relay", relay_o, 1);
    chk("avg", bus_average_readout_o, 12'h28A);
    chk("permit3", run_permit_o, 1);
    two_wire_i = 1'b1;
    run_pin_i = 2'h1;
    tick(3);
    chk("permit2", run_permit_o, 0);
    run_pin_i = 2'h3;
    run_cmd = 1'b1;
    tick(4);
    chk("inv_on", inv_en_o, 1);
    // coast and coast-input both coast; the second run has the alarm masked
    for (int k = 0; k < 2; k++) begin
      mode_i = k ? MODE_COAST_IN : MODE_COAST;
      alarm_mask_loss_i = !k;
      vbus_i = 12'h1D6; // 470 V
      tick(2);
      chk("alarm", alarm_loss_o, 1);
      chk("inv_off", inv_en_o, 0);
      chk("status", status_alarm_o, !k);
      chk("timer", loss_timer_o > 0, 1);
      vbus_i = 12'h28A;
      tick(15);
      vbus_i = 12'h1F4;
      tick(1);
      vbus_i = 12'h28A;
      tick(15);
      chk("alarm_hold", alarm_loss_o, 1);
      recov;
      chk("alarm_clr", alarm_loss_o, 0);
      chk("recon", r, 1);
      chk("accel", a, 1);
    end
    mode_i = MODE_DECEL;
    vbus_i = 12'h212; // 530 V
    tick(2);
    chk("inertia", decel_reg_o, 1);
    chk("inv_keep", inv_en_o, 1);
    chk("vinertia", vinertia_o, 12'h28A);
    recov;
    chk("no_recon", r, 0);
    chk("accel_dir", a, 1);
    vbus_i = 12'h212;
    tick(2);
    zero_req = 1'b1;
    tick(3);
    chk("zero_off", inv_en_o, 0);
    zero_req = 1'b0;
    recov;
    mode_i = MODE_CONTINUE;
    not_stop_pin_i = 2'h1;
    tick(4);
    chk("prog_stop", prog_stop_o, 1);
    not_stop_pin_i = 2'h3;
    enable_pin_i = 2'h2;
    tick(4);
    chk("en_off", inv_en_o, 0);
    enable_pin_i = 2'h3;
    mode_i = MODE_COAST;
    {fault_mask_loss_i, fault_mask_uv_i} = 2'h3;
    loss_time_i = 32'h0000_000A;
    vbus_i = 12'h1CC; // 460 V
    tick(2);
    chk("relay_open", relay_o, 0);
    tick(12);
    chk("tmo_fault", loss_timeout_fault_o, 1);
    vbus_i = 12'h21C; // 540 V
    tick(2);
    chk("relay_close", relay_o, 1);
    vbus_i = 12'h12C; // 300 V
    tick(2);
    chk("uv_fault", undervoltage_fault_o, 1);
    chk("permit_flt", run_permit_o, 0);
    test_done;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    test_done;
  end
endmodule : test_bus_power_loss_ride_through
`default_nettype wire
